// ==== rtl/eeprom_defines.svh ====
// Constants for the serial memory command engine: opcodes, status layout,
// reset values and write cycle timing.
// Assumes the including file supplies the module context.
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

// Instruction codes, sent most significant bit first
`define OP_WRITE_ENABLE  8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ   8'h05
`define OP_STATUS_WRITE  8'h01
`define OP_READ          8'h03
`define OP_WRITE         8'h02
`define OP_NONE          8'h00

// Status register bit positions
`define ST_BUSY        0
`define ST_WRITE_LATCH 1
`define ST_GUARD_LOW   2
`define ST_GUARD_HIGH  3
`define ST_ID_LOCK     4
`define ST_ID_SELECT   6
`define ST_PIN_GUARD   7

// Reset values of the status fields
`define RST_GUARD      2'h0
`define RST_PIN_GUARD  1'h0
`define RST_ID_LOCK    1'h0

// Geometry
`define ADDR_BITS      16
`define PAGE_BITS      7

// Self-timed write cycle
`define CLK_MHZ        10
`define T_WRITE_US     5000
`define WRITE_CYCLES   (`T_WRITE_US * `CLK_MHZ)

`endif

// ==== rtl/eeprom_pkg.sv ====
// Types shared by the serial memory command engine.
// Assumes nothing of its surroundings.
package eeprom_pkg;

	// Action that a rising chip select would commit
	typedef enum logic [2:0] {
		PEND_NONE,
		PEND_WEL_SET,
		PEND_WEL_CLR,
		PEND_STATUS,
		PEND_MEMORY,
		PEND_READ_DONE
	} pend_t;

	// Internal write cycle sequencer
	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_COPY,
		CYC_WAIT
	} cycle_t;

endpackage

// ==== rtl/spi_eeprom_command_engine.sv ====
// Serial-peripheral slave command engine with main array, identification
// page, status register and self-timed write cycle.
// Assumes sck, si and hold_n come from the host and are timed to sck;
// cs_n and protect_n are synchronised into clk; reset_n is power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defines.svh"

module spi_eeprom_command_engine
	import eeprom_pkg::*;
#(
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic si,
	input  wire logic hold_n,
	input  wire logic protect_n,
	output var  logic so,
	output var  logic so_oe,
	output var  logic write_busy
);

	localparam int          PAGE_BYTES = 1 << `PAGE_BITS;
	localparam int          MEM_BYTES  = 1 << `ADDR_BITS;
	localparam logic [31:0] WAIT_LAST  = 32'(WRITE_CYCLES - 1);

	// Nonvolatile and volatile storage
	logic [7:0]              mem_array [MEM_BYTES];
	logic [7:0]              id_array  [PAGE_BYTES];
	logic [7:0]              page_buf  [PAGE_BYTES];

	// Link side
	logic                    frame_rst;
	logic                    out_rst;
	logic [2:0]              bit_idx;
	logic [1:0]              byte_cnt;
	logic [7:0]              shift_reg;
	logic [7:0]              byte_in;
	logic                    byte_done;
	logic                    op_ok;
	logic [7:0]              opcode_reg;
	logic [`ADDR_BITS-1:0]   addr_reg;
	logic [7:0]              sr_data_reg;
	pend_t                   pend_reg;
	logic [PAGE_BYTES-1:0]   mask_reg;
	logic [7:0]              status_meta;
	logic [7:0]              status_s;
	logic                    rd_active;
	logic [7:0]              rd_byte;

	// Core side
	logic                    cs_meta;
	logic                    cs_sync;
	logic                    cs_last;
	logic                    wp_meta;
	logic                    wp_sync;
	logic                    wp_last;
	logic                    cs_rise;
	logic                    cs_fall;
	logic                    wp_fall;
	logic                    wp_fell_reg;
	logic                    wel_reg;
	logic [1:0]              guard_reg;
	logic                    pin_guard_reg;
	logic                    id_lock_reg;
	logic                    id_sel_reg;
	logic [7:0]              status_byte;
	cycle_t                  cyc_reg;
	logic [`PAGE_BITS-1:0]   copy_idx;
	logic [31:0]             timer_reg;
	logic                    to_id_reg;
	logic                    mem_cycle_reg;
	logic [`ADDR_BITS-`PAGE_BITS-1:0] page_base;
	logic                    sr_ok;
	logic                    mem_guarded;
	logic                    mem_ok;
	logic                    cycle_end;

	function automatic logic guarded(input logic [1:0] bp, input logic [`ADDR_BITS-1:0] a);
		case (bp)
			2'h1:    guarded = (a[`ADDR_BITS-1 -: 2] == 2'h3);
			2'h2:    guarded = a[`ADDR_BITS-1];
			2'h3:    guarded = 1'b1;
			default: guarded = 1'b0;
		endcase
	endfunction

	function automatic logic known_op(input logic [7:0] op);
		case (op)
			`OP_WRITE_ENABLE, `OP_WRITE_DISABLE, `OP_STATUS_READ,
			`OP_STATUS_WRITE, `OP_READ, `OP_WRITE: known_op = 1'b1;
			default: known_op = 1'b0;
		endcase
	endfunction

	// ---------------- Link domain (sck) ----------------

	assign frame_rst = cs_n | ~reset_n;
	assign out_rst   = frame_rst | ~hold_n;
	assign byte_in   = {shift_reg[6:0], si};
	assign byte_done = hold_n & (bit_idx == 3'h7);
	assign op_ok     = known_op(byte_in) &
		(~status_s[`ST_BUSY] | (byte_in == `OP_STATUS_READ));

	// Bit and byte counting; a frame restarts whenever select is high
	always_ff @(posedge sck or posedge frame_rst) begin
		if (frame_rst) begin
			bit_idx   <= 3'h0;
			byte_cnt  <= 2'h0;
			shift_reg <= 8'h00;
		end else if (hold_n) begin
			bit_idx   <= bit_idx + 3'h1;
			shift_reg <= byte_in;
			if (bit_idx == 3'h7 && byte_cnt != 2'h3) begin
				byte_cnt <= byte_cnt + 2'h1;
			end
		end
	end

	// Opcode and address; kept past select rise for the commit
	always_ff @(posedge sck or negedge reset_n) begin
		if (!reset_n) begin
			opcode_reg  <= `OP_NONE;
			addr_reg    <= '0;
			sr_data_reg <= 8'h00;
		end else if (byte_done) begin
			case (byte_cnt)
				2'h0: begin
					opcode_reg <= op_ok ? byte_in : `OP_NONE;
				end
				2'h1: begin
					addr_reg[15:8] <= byte_in;
					sr_data_reg    <= byte_in;
				end
				2'h2: begin
					addr_reg[7:0] <= byte_in;
				end
				default: begin
					if (opcode_reg == `OP_READ) begin
						if (status_s[`ST_ID_SELECT]) begin
							addr_reg[`PAGE_BITS-1:0] <= addr_reg[`PAGE_BITS-1:0] + 7'h01;
						end else begin
							addr_reg <= addr_reg + 16'h0001;
						end
					end else if (opcode_reg == `OP_WRITE) begin
						addr_reg[`PAGE_BITS-1:0] <= addr_reg[`PAGE_BITS-1:0] + 7'h01;
					end
				end
			endcase
		end
	end

	// What a rising select would commit; any partial byte cancels writes
	always_ff @(posedge sck or negedge reset_n) begin
		if (!reset_n) begin
			pend_reg <= PEND_NONE;
		end else if (hold_n) begin
			if (!byte_done) begin
				if (byte_cnt == 2'h0 || pend_reg != PEND_READ_DONE) begin
					pend_reg <= PEND_NONE;
				end
			end else begin
				case (byte_cnt)
					2'h0: begin
						if (op_ok && byte_in == `OP_WRITE_ENABLE) begin
							pend_reg <= PEND_WEL_SET;
						end else if (op_ok && byte_in == `OP_WRITE_DISABLE) begin
							pend_reg <= PEND_WEL_CLR;
						end else begin
							pend_reg <= PEND_NONE;
						end
					end
					2'h1: begin
						pend_reg <= (opcode_reg == `OP_STATUS_WRITE) ? PEND_STATUS : PEND_NONE;
					end
					2'h2: begin
						pend_reg <= (opcode_reg == `OP_READ) ? PEND_READ_DONE : PEND_NONE;
					end
					default: begin
						if (opcode_reg == `OP_WRITE) begin
							pend_reg <= PEND_MEMORY;
						end else if (opcode_reg == `OP_READ) begin
							pend_reg <= PEND_READ_DONE;
						end else begin
							pend_reg <= PEND_NONE;
						end
					end
				endcase
			end
		end
	end

	// Which page buffer entries were loaded in this frame
	always_ff @(posedge sck or negedge reset_n) begin
		if (!reset_n) begin
			mask_reg <= '0;
		end else if (byte_done) begin
			if (byte_cnt == 2'h0 && op_ok && byte_in == `OP_WRITE) begin
				mask_reg <= '0;
			end else if (byte_cnt == 2'h3 && opcode_reg == `OP_WRITE) begin
				mask_reg[addr_reg[`PAGE_BITS-1:0]] <= 1'b1;
			end
		end
	end

	always_ff @(posedge sck) begin
		if (byte_done && byte_cnt == 2'h3 && opcode_reg == `OP_WRITE) begin
			page_buf[addr_reg[`PAGE_BITS-1:0]] <= byte_in;
		end
	end

	// Status into the link domain
	always_ff @(posedge sck or negedge reset_n) begin
		if (!reset_n) begin
			status_meta <= 8'h00;
			status_s    <= 8'h00;
		end else begin
			status_meta <= status_byte;
			status_s    <= status_meta;
		end
	end

	assign rd_active = ((opcode_reg == `OP_READ) && (byte_cnt == 2'h3)) ||
		((opcode_reg == `OP_STATUS_READ) && (byte_cnt != 2'h0));

	always_comb begin
		if (opcode_reg == `OP_STATUS_READ) begin
			rd_byte = status_s;
		end else if (status_s[`ST_ID_SELECT]) begin
			rd_byte = id_array[addr_reg[`PAGE_BITS-1:0]];
		end else begin
			rd_byte = mem_array[addr_reg];
		end
	end

	// Output shifts on the falling edge; off when idle, paused or unknown
	always_ff @(negedge sck or posedge out_rst) begin
		if (out_rst) begin
			so    <= 1'b0;
			so_oe <= 1'b0;
		end else begin
			so_oe <= rd_active;
			so    <= rd_byte[3'h7 - bit_idx];
		end
	end

	// ---------------- Core domain (clk) ----------------

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_last <= 1'b1;
			wp_meta <= 1'b1;
			wp_sync <= 1'b1;
			wp_last <= 1'b1;
		end else begin
			cs_meta <= cs_n;
			cs_sync <= cs_meta;
			cs_last <= cs_sync;
			wp_meta <= protect_n;
			wp_sync <= wp_meta;
			wp_last <= wp_sync;
		end
	end

	assign cs_rise = cs_sync & ~cs_last;
	assign cs_fall = ~cs_sync & cs_last;
	assign wp_fall = ~wp_sync & wp_last;

	// Protect pin fell inside the current frame; the set wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wp_fell_reg <= 1'b0;
		end else if (wp_fall && !cs_sync) begin
			wp_fell_reg <= 1'b1;
		end else if (cs_fall) begin
			wp_fell_reg <= 1'b0;
		end
	end

	assign status_byte = {pin_guard_reg, id_sel_reg, 1'b0, id_lock_reg,
		guard_reg, wel_reg, write_busy};
	assign cycle_end   = (cyc_reg == CYC_WAIT) && (timer_reg == WAIT_LAST);
	assign sr_ok       = cs_rise && (pend_reg == PEND_STATUS) && wel_reg &&
		!(pin_guard_reg && (!wp_sync || wp_fell_reg));
	assign mem_guarded = id_sel_reg ?
		(id_lock_reg ||
		guarded(guard_reg, {9'h000, addr_reg[`PAGE_BITS-1:0]})) :
		guarded(guard_reg, addr_reg);
	assign mem_ok      = cs_rise && (pend_reg == PEND_MEMORY) && wel_reg && !mem_guarded;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wel_reg <= 1'b0;
		end else if (cycle_end) begin
			wel_reg <= 1'b0;
		end else if (cs_rise && pend_reg == PEND_WEL_SET) begin
			wel_reg <= 1'b1;
		end else if (cs_rise && pend_reg == PEND_WEL_CLR) begin
			wel_reg <= 1'b0;
		end
	end

	// Status fields
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			guard_reg     <= `RST_GUARD;
			pin_guard_reg <= `RST_PIN_GUARD;
			id_lock_reg   <= `RST_ID_LOCK;
			id_sel_reg    <= 1'b0;
		end else if (sr_ok) begin
			guard_reg     <= sr_data_reg[`ST_GUARD_HIGH:`ST_GUARD_LOW];
			pin_guard_reg <= sr_data_reg[`ST_PIN_GUARD];
			if (!(sr_data_reg[`ST_ID_SELECT] && sr_data_reg[`ST_ID_LOCK])) begin
				id_sel_reg  <= sr_data_reg[`ST_ID_SELECT];
				id_lock_reg <= id_lock_reg | sr_data_reg[`ST_ID_LOCK];
			end
		end else if (cs_rise && pend_reg == PEND_READ_DONE) begin
			id_sel_reg <= 1'b0;
		end else if (cs_rise && pend_reg == PEND_MEMORY && !mem_ok) begin
			id_sel_reg <= 1'b0;
		end else if (cycle_end && mem_cycle_reg) begin
			id_sel_reg <= 1'b0;
		end
	end

	// Internal write cycle: copy loaded bytes, then wait out the timer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc_reg       <= CYC_IDLE;
			write_busy    <= 1'b0;
			copy_idx      <= '0;
			timer_reg     <= 32'h0000_0000;
			to_id_reg     <= 1'b0;
			mem_cycle_reg <= 1'b0;
			page_base     <= '0;
		end else begin
			case (cyc_reg)
				CYC_IDLE: begin
					if (mem_ok) begin
						cyc_reg       <= CYC_COPY;
						write_busy    <= 1'b1;
						copy_idx      <= '0;
						to_id_reg     <= id_sel_reg;
						mem_cycle_reg <= 1'b1;
						page_base     <= addr_reg[`ADDR_BITS-1:`PAGE_BITS];
					end else if (sr_ok) begin
						cyc_reg       <= CYC_WAIT;
						write_busy    <= 1'b1;
						timer_reg     <= 32'h0000_0000;
						mem_cycle_reg <= 1'b0;
					end
				end
				CYC_COPY: begin
					copy_idx <= copy_idx + 7'h01;
					if (copy_idx == 7'h7F) begin
						cyc_reg   <= CYC_WAIT;
						timer_reg <= 32'h0000_0000;
					end
				end
				CYC_WAIT: begin
					timer_reg <= timer_reg + 32'h0000_0001;
					if (timer_reg == WAIT_LAST) begin
						cyc_reg    <= CYC_IDLE;
						write_busy <= 1'b0;
					end
				end
				default: begin
					cyc_reg    <= CYC_IDLE;
					write_busy <= 1'b0;
				end
			endcase
		end
	end

	// Programming; link side loading is refused while busy
	always_ff @(posedge clk) begin
		if (cyc_reg == CYC_COPY && mask_reg[copy_idx]) begin
			if (to_id_reg) begin
				id_array[copy_idx] <= page_buf[copy_idx];
			end else begin
				mem_array[{page_base, copy_idx}] <= page_buf[copy_idx];
			end
		end
	end

endmodule
`default_nettype wire

// ==== test/eeprom_engine_chk.sv ====
// Port checker for the serial memory engine.
// Assumes it is bound to every engine instance.
`timescale 1ns/1ps
`default_nettype none
module eeprom_engine_chk #(
	parameter int WRITE_CYCLES = 20
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic hold_n,
	input wire logic protect_n,
	input wire logic so,
	input wire logic so_oe,
	input wire logic write_busy
);
	// Status write waits the timer only; memory write copies 128 entries first
	localparam int BUSY_SR  = WRITE_CYCLES;
	localparam int BUSY_MEM = WRITE_CYCLES + 128;
	int         busy_reg;
	logic [3:0] edge_reg;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			busy_reg <= 0;
		else
			busy_reg <= write_busy ? busy_reg + 1 : 0;
	end
	// Rising sck edges in the frame, paused edges left out
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n)
			edge_reg <= 4'h0;
		else if (hold_n && edge_reg != 4'hF)
			edge_reg <= edge_reg + 4'h1;
	end
	cs_oe_a: assert property (@(posedge clk) disable iff (!reset_n)
		cs_n |-> !so_oe) else $error("so on while deselected");
	hold_oe_a: assert property (@(posedge clk) disable iff (!reset_n)
		!hold_n |-> !so_oe) else $error("so on while paused");
	op_oe_a: assert property (@(posedge sck) disable iff (cs_n)
		so_oe |-> edge_reg >= 4'h8) else $error("so on before opcode end");
	busy_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(write_busy) |-> cs_n && $past(cs_n, 2)) else $error("busy without cs rise");
	busy_min_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(write_busy) |-> (busy_reg == BUSY_SR) || (busy_reg == BUSY_MEM))
		else $error("busy length wrong");
	busy_max_a: assert property (@(posedge clk) disable iff (!reset_n)
		busy_reg <= BUSY_MEM) else $error("busy too long");
	busy_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(write_busy) |=> write_busy [*8]) else $error("busy dropped early");
	sel_start_a: assert property (@(posedge clk) disable iff (!reset_n)
		!cs_n && !$past(cs_n, 4) |-> !$rose(write_busy)) else $error("write while selected");
endmodule
bind spi_eeprom_command_engine eeprom_engine_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
	.clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
	.protect_n(protect_n), .so(so), .so_oe(so_oe), .write_busy(write_busy)
);
`default_nettype wire

// ==== test/spi_host_model.sv ====
// Host serial controller model, mode 0, sck still between frames.
// Assumes the engine samples si on rising sck and drives so on falling sck.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output var  logic sck,
	output var  logic cs_n,
	output var  logic si,
	output var  logic hold_n,
	input  wire logic so,
	input  wire logic so_oe
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
	end
	task automatic sel(input logic on);
		#10 cs_n = ~on;
	endtask
	// Whole byte, si set while sck low
	task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic oe);
		oe = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			si = b[i];
			#3 sck = 1'b1;
			// Released line reads as the inverse so stale data cannot pass
			r[i] = so_oe ? so : ~so;
			oe |= so_oe;
			#3 sck = 1'b0;
		end
	endtask
	// Pause entered with sck low; sck and si keep moving to show they are ignored
	task automatic pause(output logic oe);
		#2 hold_n = 1'b0;
		oe = 1'b0;
		repeat (4) begin
			si = ~si;
			#3 sck = 1'b1;
			oe |= so_oe;
			#3 sck = 1'b0;
		end
		#2 hold_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== test/spi_eeprom_command_engine_tb.sv ====
// Self-checking bench for the serial memory engine.
// Assumes the host model on the link and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_defines.svh"
module spi_eeprom_command_engine_tb;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        protect_n = 1'b1;
	wire         sck, cs_n, si, hold_n, so, so_oe, write_busy;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;
	logic [15:0] lf = 16'hF8FE;
	logic [7:0]  tx[$], rx[$], wd[$], sv[3], r;
	logic        oq[$], o;
	logic [15:0] ad[3];
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			end_sim();
		end
	end
	spi_eeprom_command_engine #(.WRITE_CYCLES(60)) DUT (
		.clk(clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
		.protect_n(protect_n), .so(so), .so_oe(so_oe), .write_busy(write_busy)
	);
	spi_host_model host (
		.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe)
	);
	function automatic logic [7:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction
	// Writable status bits; page select with lock in one write keeps both clear
	function automatic logic [7:0] st_exp(input logic [7:0] w);
		return (w[6] & w[4]) ? w & 8'h8C : w & 8'hDC;
	endfunction
	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t byte %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %0t bit %b want %b", $time, g, e);
		end
	endtask
	task automatic open();
		@(negedge clk);
		host.sel(1'b1);
	endtask
	// Deselect, then leave room for the commit to land
	task automatic close();
		host.sel(1'b0);
		repeat (6) @(negedge clk);
	endtask
	task automatic run();
		rx = {};
		oq = {};
		open();
		foreach (tx[i]) begin
			host.xfer(tx[i], r, o);
			rx.push_back(r);
			oq.push_back(o);
		end
		close();
	endtask
	task automatic st(input logic [7:0] e, input logic [7:0] m);
		tx = {`OP_STATUS_READ, 8'h00, 8'h00};
		run();
		chk_byte(rx[1] & m, e & m);
		chk_byte(rx[2] & m, e & m);
	endtask
	task automatic commit(input logic ok);
		int n;
		chk_bit(write_busy, ok);
		if (ok) begin
			st(8'h03, 8'h03);
			tx = {`OP_WRITE_DISABLE};
			run();
			st(8'h03, 8'h03);
			for (n = 0; n < 400 && write_busy === 1'b1; n++)
				@(negedge clk);
			chk_bit(write_busy, 1'b0);
			st(8'h00, 8'h03);
		end
	endtask
	task automatic wr(input logic [15:0] a, input int n, input logic ok);
		tx = {`OP_WRITE_ENABLE};
		run();
		wd = {};
		repeat (n) wd.push_back(rnd());
		tx = {`OP_WRITE, a[15:8], a[7:0]};
		tx = {tx, wd};
		run();
		commit(ok);
	endtask
	task automatic sw(input logic [7:0] v, input logic ok);
		tx = {`OP_WRITE_ENABLE};
		run();
		tx = {`OP_STATUS_WRITE, v};
		run();
		commit(ok);
	endtask
	task automatic rd(input logic [15:0] a, input int n);
		tx = {`OP_READ, a[15:8], a[7:0]};
		repeat (n) tx.push_back(8'h00);
		run();
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		st(8'h00, 8'hFF);
		tx = {`OP_WRITE_ENABLE, 8'h00};
		run();
		st(8'h00, 8'hFF);
		tx = {`OP_WRITE_ENABLE};
		run();
		st(8'h02, 8'hFF);
		tx = {`OP_WRITE_DISABLE};
		run();
		st(8'h00, 8'hFF);
		tx = {`OP_WRITE, 8'h00, 8'h40, 8'h5A};
		run();
		commit(1'b0);
		$display("test latch done");
		wr(16'h017E, 4, 1'b1);
		rd(16'h017E, 2);
		chk_byte(rx[3], wd[0]);
		chk_byte(rx[4], wd[1]);
		chk_bit(oq[3], 1'b1);
		rd(16'h0100, 2);
		chk_byte(rx[3], wd[2]);
		chk_byte(rx[4], wd[3]);
		ad = '{16'hFFFF, 16'h0000, {rnd(), rnd()}};
		for (int k = 0; k < 3; k++) begin
			wr(ad[k], 1, 1'b1);
			sv[k] = wd[0];
			rd(ad[k], 1);
			chk_byte(rx[3], sv[k]);
		end
		rd(16'hFFFF, 2);
		chk_byte(rx[4], sv[1]);
		$display("test memory done");
		sw(8'hFF, 1'b1);
		st(st_exp(8'hFF), 8'hFC);
		protect_n = 1'b0;
		sw(8'h00, 1'b0);
		protect_n = 1'b1;
		tx = {`OP_WRITE_ENABLE};
		run();
		open();
		host.xfer(`OP_STATUS_WRITE, r, o);
		@(negedge clk);
		protect_n = 1'b0;
		repeat (5) @(negedge clk);
		protect_n = 1'b1;
		repeat (5) @(negedge clk);
		host.xfer(8'h00, r, o);
		close();
		commit(1'b0);
		st(8'h8C, 8'hFC);
		sw(8'h00, 1'b1);
		protect_n = 1'b0;
		sw(8'h0C, 1'b1);
		st(8'h0C, 8'hFC);
		protect_n = 1'b1;
		sw(8'h4C, 1'b1);
		wr(16'hAB05, 1, 1'b0);
		sw(8'h40, 1'b1);
		wr(16'hAB05, 1, 1'b1);
		sv[0] = wd[0];
		st(8'h00, 8'h40);
		sw(8'h40, 1'b1);
		rd(16'h0005, 1);
		chk_byte(rx[3], sv[0]);
		st(8'h00, 8'h40);
		sw(8'h10, 1'b1);
		sw(8'h40, 1'b1);
		wr(16'h0005, 1, 1'b0);
		st(8'h10, 8'hFC);
		$display("test status done");
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			if (r inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02})
				r = 8'hFF;
			tx = {r, 8'h00, 8'h00, 8'h00};
			run();
			chk_bit(oq.or(), 1'b0);
		end
		st(8'h02, 8'h03);
		tx = {`OP_WRITE_DISABLE};
		run();
		st(8'h00, 8'h03);
		open();
		host.pause(o);
		host.xfer(`OP_WRITE_ENABLE, r, o);
		close();
		st(8'h02, 8'h03);
		open();
		host.xfer(`OP_STATUS_READ, r, o);
		host.pause(o);
		chk_bit(o, 1'b0);
		close();
		$display("test pause done");
		end_sim();
	end
endmodule
`default_nettype wire
